// file: logic/spectral_alarm_reporting.v
// Spectral alarm reporting: per-axis band alarm status, worst peak and bin, alarm pins.
// Assumes the FFT engine streams bins with a band tag, and config words come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_report_defs.vh"

module spectral_alarm_reporting (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // Configuration words from the register file
  input  wire [15:0] aux_pin_config,
  input  wire [15:0] alarm_config,
  input  wire [15:0] x_level_one_threshold,
  input  wire [15:0] y_level_one_threshold,
  input  wire [15:0] z_level_one_threshold,
  input  wire [15:0] x_level_two_threshold,
  input  wire [15:0] y_level_two_threshold,
  input  wire [15:0] z_level_two_threshold,
  input  wire [15:0] diagnostic_status,
  // FFT bin stream
  input  wire        rec_start,
  input  wire        rec_done,
  input  wire        bin_valid,
  input  wire [2:0]  bin_band,
  input  wire [7:0]  bin_index,
  input  wire [15:0] x_bin_mag,
  input  wire [15:0] y_bin_mag,
  input  wire [15:0] z_bin_mag,
  // Register read port
  input  wire        rd_en,
  input  wire [6:0]  rd_addr,
  output reg  [15:0] rd_data_q,
  output reg         rd_valid_q,
  // Record header copy
  output reg         hdr_valid_q,
  output reg  [5:0]  hdr_generic_flags_q,
  // Auxiliary pins
  output reg         aux_pin_one_out_q,
  output reg         aux_pin_one_oe_q,
  output reg         aux_pin_two_out_q,
  output reg         aux_pin_two_oe_q
);

  wire [15:0] run_status [0:2];
  wire [15:0] run_peak   [0:2];
  wire [7:0]  run_bin    [0:2];
  wire [15:0] mag        [0:2];
  wire [15:0] lvl1       [0:2];
  wire [15:0] lvl2       [0:2];

  reg  [15:0] band_alarm_status_q [0:2];
  reg  [15:0] worst_peak_q        [0:2];
  reg  [7:0]  worst_bin_q         [0:2];

  reg  [15:0] rd_data_d;
  reg         any_warn;
  reg         any_crit;
  reg         pin_one_sel;
  reg         pin_two_sel;
  integer     i;
  integer     j;

  // True when any flag picked by the mask is set in a band alarm status word.
  function flags_hit;
    input [15:0] word;
    input [11:0] mask;
    begin
      flags_hit = |(word[`FLAG_FIELD_HI:`FLAG_FIELD_LO] & mask);
    end
  endfunction

  assign mag[0]  = x_bin_mag;
  assign mag[1]  = y_bin_mag;
  assign mag[2]  = z_bin_mag;
  assign lvl1[0] = x_level_one_threshold;
  assign lvl1[1] = y_level_one_threshold;
  assign lvl1[2] = z_level_one_threshold;
  assign lvl2[0] = x_level_two_threshold;
  assign lvl2[1] = y_level_two_threshold;
  assign lvl2[2] = z_level_two_threshold;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : axis
      axis_band_eval axis_band_eval_i (
        .clk_sys             (clk_sys),
        .resetn              (resetn),
        .rec_start           (rec_start),
        .bin_valid           (bin_valid),
        .bin_band            (bin_band),
        .bin_index           (bin_index),
        .bin_mag             (mag[g]),
        .level_one_threshold (lvl1[g]),
        .level_two_threshold (lvl2[g]),
        .status_q            (run_status[g]),
        .peak_q              (run_peak[g]),
        .peak_bin_q          (run_bin[g])
      );
    end
  endgenerate

  // Published results change only at record end, so a host read mid-record sees the last record whole.
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        band_alarm_status_q[i] <= `RST_WORD16;
        worst_peak_q[i]        <= `RST_WORD16;
        worst_bin_q[i]         <= `RST_BYTE;
      end
      hdr_valid_q         <= 1'b0;
      hdr_generic_flags_q <= `RST_GENERIC;
    end
    else
    begin
      hdr_valid_q <= rec_done;
      if (rec_done)
      begin
        for (i = 0; i < 3; i = i + 1)
        begin
          band_alarm_status_q[i] <= run_status[i];
          worst_peak_q[i]        <= run_peak[i];
          worst_bin_q[i]         <= run_bin[i];
        end
        hdr_generic_flags_q <= diagnostic_status[`GENERIC_FLAGS_HI:`GENERIC_FLAGS_LO];
      end
    end
  end

  always @*
  begin
    any_warn = 1'b0;
    any_crit = 1'b0;
    // A critical band also sets its warning bit, so pin one, when selected, rises along with pin two.
    for (j = 0; j < 3; j = j + 1)
    begin
      // Level-one and level-two bits alternate across the flag field.
      any_warn = any_warn | flags_hit(band_alarm_status_q[j], `LEVEL_ONE_MASK);
      any_crit = any_crit | flags_hit(band_alarm_status_q[j], `LEVEL_TWO_MASK);
    end
    pin_one_sel = alarm_config[`ALARM_ENABLE_BIT] & aux_pin_config[`PIN_ONE_ALARM_SEL_BIT];
    pin_two_sel = alarm_config[`ALARM_ENABLE_BIT] & aux_pin_config[`PIN_TWO_ALARM_SEL_BIT];
  end

  // A released pin keeps its enable low, so the board's bias decides its level then.
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      aux_pin_one_out_q <= 1'b0;
      aux_pin_one_oe_q  <= 1'b0;
      aux_pin_two_out_q <= 1'b0;
      aux_pin_two_oe_q  <= 1'b0;
    end
    else
    begin
      aux_pin_one_oe_q  <= pin_one_sel;
      aux_pin_one_out_q <= pin_one_sel & any_warn;
      aux_pin_two_oe_q  <= pin_two_sel;
      aux_pin_two_out_q <= pin_two_sel & any_crit;
    end
  end

  always @*
  begin
    case (rd_addr)
      `ADDR_X_BAND_ALARM_STATUS: rd_data_d = band_alarm_status_q[0];
      `ADDR_Y_BAND_ALARM_STATUS: rd_data_d = band_alarm_status_q[1];
      `ADDR_Z_BAND_ALARM_STATUS: rd_data_d = band_alarm_status_q[2];
      `ADDR_X_WORST_PEAK:        rd_data_d = worst_peak_q[0];
      `ADDR_Y_WORST_PEAK:        rd_data_d = worst_peak_q[1];
      `ADDR_Z_WORST_PEAK:        rd_data_d = worst_peak_q[2];
      `ADDR_X_WORST_BIN:         rd_data_d = {`RST_BYTE, worst_bin_q[0]};
      `ADDR_Y_WORST_BIN:         rd_data_d = {`RST_BYTE, worst_bin_q[1]};
      `ADDR_Z_WORST_BIN:         rd_data_d = {`RST_BYTE, worst_bin_q[2]};
      default:                   rd_data_d = `RST_WORD16;
    endcase
  end

  // Read data holds between reads, so a slow host may still sample it late.
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      rd_data_q  <= `RST_WORD16;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_en;
      if (rd_en)
        rd_data_q <= rd_data_d;
    end
  end

endmodule // spectral_alarm_reporting
`default_nettype wire

// file: logic/alarm_report_defs.vh
// Constants shared by the spectral alarm reporting block.
// Assumes inclusion inside the design files only; definitions only, no logic.
`ifndef ALARM_REPORT_DEFS_VH
`define ALARM_REPORT_DEFS_VH

// Register byte addresses on the read port.
`define ADDR_X_BAND_ALARM_STATUS 7'h40
`define ADDR_Y_BAND_ALARM_STATUS 7'h42
`define ADDR_Z_BAND_ALARM_STATUS 7'h44
`define ADDR_X_WORST_PEAK        7'h46
`define ADDR_Y_WORST_PEAK        7'h48
`define ADDR_Z_WORST_PEAK        7'h4a
`define ADDR_X_WORST_BIN         7'h70
`define ADDR_Y_WORST_BIN         7'h72
`define ADDR_Z_WORST_BIN         7'h74

// Reset values.
`define RST_WORD16               16'h0000
`define RST_BYTE                 8'h00
`define RST_BAND                 3'h0
`define RST_SEV                  2'h0
`define RST_GENERIC              6'h00

// Field positions.
`define ALARM_ENABLE_BIT         6
`define PIN_ONE_ALARM_SEL_BIT    2
`define PIN_TWO_ALARM_SEL_BIT    3
`define GENERIC_FLAGS_HI         13
`define GENERIC_FLAGS_LO         8
`define BAND_FIELD_HI            2
`define BAND_FIELD_LO            0
`define FLAG_FIELD_HI            15
`define FLAG_FIELD_LO            4
`define LEVEL_ONE_BASE           4'h2
`define LEVEL_TWO_BASE           4'h3
`define LEVEL_ONE_MASK           12'h555
`define LEVEL_TWO_MASK           12'haaa

// Band numbering and alarm severities.
`define BAND_FIRST               3'h1
`define BAND_LAST                3'h6
`define SEV_NONE                 2'h0
`define SEV_WARN                 2'h1
`define SEV_CRIT                 2'h2
`define THRESH_OFF               16'h0000

`endif

// file: logic/axis_band_eval.v
// One axis of band alarm evaluation over a stream of FFT bins.
// Assumes bins of one record arrive between rec_start and the owner's latch pulse.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_report_defs.vh"

module axis_band_eval (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        resetn,
  // Bin stream
  input  wire        rec_start,
  input  wire        bin_valid,
  input  wire [2:0]  bin_band,
  input  wire [7:0]  bin_index,
  input  wire [15:0] bin_mag,
  // Trigger levels
  input  wire [15:0] level_one_threshold,
  input  wire [15:0] level_two_threshold,
  // Running results
  output reg  [15:0] status_q,
  output reg  [15:0] peak_q,
  output reg  [7:0]  peak_bin_q
);

  reg  [1:0]  worst_sev_q;
  reg  [1:0]  sev;
  reg         band_ok;
  reg         take;

  // A zero trigger level disables that level, so a cleared setup raises nothing.
  function [1:0] severity;
    input [15:0] mag;
    input [15:0] lvl1;
    input [15:0] lvl2;
    begin
      if (lvl2 != `THRESH_OFF && mag > lvl2)
        severity = `SEV_CRIT;
      else if (lvl1 != `THRESH_OFF && mag > lvl1)
        severity = `SEV_WARN;
      else
        severity = `SEV_NONE;
    end
  endfunction

  // Flag bit of a band; the base picks the level-one or the level-two bit.
  function [3:0] flag_pos;
    input [2:0] band;
    input [3:0] base;
    begin
      flag_pos = {band, 1'b0} + base;
    end
  endfunction

  always @*
  begin
    band_ok = (bin_band >= `BAND_FIRST) && (bin_band <= `BAND_LAST);
    sev     = band_ok ? severity(bin_mag, level_one_threshold, level_two_threshold) : `SEV_NONE;
    take    = bin_valid && ((sev > worst_sev_q) || (sev == worst_sev_q && bin_mag > peak_q));
  end

  always @(posedge clk_sys)
  begin
    if (!resetn || rec_start)
    begin
      status_q    <= `RST_WORD16;
      peak_q      <= `RST_WORD16;
      peak_bin_q  <= `RST_BYTE;
      worst_sev_q <= `RST_SEV;
    end
    else if (bin_valid)
    begin
      if (sev == `SEV_WARN || sev == `SEV_CRIT)
        status_q[flag_pos(bin_band, `LEVEL_ONE_BASE)] <= 1'b1;
      if (sev == `SEV_CRIT)
        status_q[flag_pos(bin_band, `LEVEL_TWO_BASE)] <= 1'b1;
      if (take)
      begin
        peak_q      <= bin_mag;
        peak_bin_q  <= bin_index;
        worst_sev_q <= sev;
        status_q[`BAND_FIELD_HI:`BAND_FIELD_LO] <= (sev == `SEV_NONE) ? `RST_BAND : bin_band;
      end
    end
  end

endmodule // axis_band_eval
`default_nettype wire

// file: bench/alarm_checker.sv
// Port checker for the spectral alarm reporting block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module alarm_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Inputs watched
  input wire logic [15:0] aux_pin_config,
  input wire logic [15:0] alarm_config,
  input wire logic [15:0] diagnostic_status,
  input wire logic        rec_done,
  input wire logic        rd_en,
  // Outputs watched
  input wire logic [15:0] rd_data_q,
  input wire logic        rd_valid_q,
  input wire logic        hdr_valid_q,
  input wire logic [5:0]  hdr_generic_flags_q,
  input wire logic        aux_pin_one_oe_q,
  input wire logic        aux_pin_two_oe_q,
  input wire logic        aux_pin_one_out_q,
  input wire logic        aux_pin_two_out_q
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // Three settled cycles leave room for the registered pin enables.
  sequence s_one_on;
    (alarm_config[6] && aux_pin_config[2])[*3];
  endsequence
  sequence s_two_on;
    (alarm_config[6] && aux_pin_config[3])[*3];
  endsequence
  sequence s_one_off;
    (!(alarm_config[6] && aux_pin_config[2]))[*3];
  endsequence
  sequence s_two_off;
    (!(alarm_config[6] && aux_pin_config[3]))[*3];
  endsequence
  a_read_answer: assert property (rd_en |=> rd_valid_q)
    else $error("read not answered in one cycle");
  a_read_quiet: assert property (!rd_en |=> !rd_valid_q)
    else $error("read valid without a request");
  a_read_hold: assert property (!rd_en |=> $stable(rd_data_q))
    else $error("read data moved without a request");
  a_hdr_pulse: assert property (rec_done |=> hdr_valid_q ##1 (hdr_valid_q == $past(rec_done)))
    else $error("header pulse missing after record end");
  a_hdr_flags: assert property (rec_done |=> hdr_generic_flags_q == $past(diagnostic_status[13:8]))
    else $error("header flags differ from diagnostic status");
  a_pin_one_drive: assert property (s_one_on |-> aux_pin_one_oe_q)
    else $error("pin one not driven when enabled");
  a_pin_two_drive: assert property (s_two_on |-> aux_pin_two_oe_q)
    else $error("pin two not driven when enabled");
  a_pin_one_off: assert property (s_one_off |-> !aux_pin_one_oe_q)
    else $error("pin one driven while not enabled");
  a_pin_two_off: assert property (s_two_off |-> !aux_pin_two_oe_q)
    else $error("pin two driven while not enabled");
  a_pin_one_gated: assert property (aux_pin_one_out_q |-> aux_pin_one_oe_q)
    else $error("pin one high while released");
  a_pin_two_gated: assert property (aux_pin_two_out_q |-> aux_pin_two_oe_q)
    else $error("pin two high while released");
endmodule // alarm_checker
bind spectral_alarm_reporting alarm_checker alarm_checker_i (.clk_sys, .resetn, .aux_pin_config,
  .alarm_config, .diagnostic_status, .rec_done, .rd_en, .rd_data_q, .rd_valid_q, .hdr_valid_q,
  .hdr_generic_flags_q, .aux_pin_one_oe_q, .aux_pin_two_oe_q, .aux_pin_one_out_q, .aux_pin_two_out_q);
`default_nettype wire

// file: bench/host_model.sv
// Host model: owns the config words and reads result registers.
// Assumes the bench calls its tasks; it drives at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clk_sys,
  // Register read port
  input  wire logic [15:0] rd_data_q,
  input  wire logic        rd_valid_q,
  output var  logic        rd_en = 1'b0,
  output var  logic [6:0]  rd_addr = 7'h00,
  // Config words
  output var  logic [15:0] aux_pin_config = 16'h0000,
  output var  logic [15:0] alarm_config = 16'h0000
);
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(negedge clk_sys);
    rd_en = 1'b1;
    rd_addr = a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(negedge clk_sys);
      rd_en = 1'b0;
      if (rd_valid_q === 1'b1)
      begin
        ok = 1'b1;
        d = rd_data_q;
      end
    end
  endtask
  task automatic cfg(input logic [3:0] sel, input logic en);
    @(negedge clk_sys);
    aux_pin_config = {10'h000, sel, 2'h0};
    alarm_config = 16'h0000;
    @(negedge clk_sys);
    alarm_config = {9'h000, en, 6'h00};
  endtask
endmodule // host_model
`default_nettype wire

// file: bench/spectral_alarm_reporting_tb.sv
// Bench for spectral alarm reporting: reset values, one record per band, pins.
// Assumes the host model owns the read port and the config words.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: %h vs %h", $time, a, b); end end
module spectral_alarm_reporting_tb;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        rec_start = 1'b0, rec_done = 1'b0, bin_valid = 1'b0;
  logic [2:0]  bin_band = 3'h0;
  logic [7:0]  bin_index = 8'h00;
  logic [15:0] xm = 16'h0000, ym = 16'h0000, zm = 16'h0000, diagnostic_status = 16'h0000;
  logic [15:0] l1 = 16'h0064, l2 = 16'h00c8, lz2 = 16'h0028;
  wire  [15:0] rd_data_q, aux_pin_config, alarm_config;
  wire  [6:0]  rd_addr;
  wire         rd_en, rd_valid_q, p1o, p1e, p2o, p2e;
  int          bad_count = 0, samples_checked = 0;
  logic [6:0]  regs [0:9] = '{7'h40, 7'h42, 7'h44, 7'h46, 7'h48, 7'h4a, 7'h70, 7'h72, 7'h74, 7'h4c};
  always #10 clk_sys = ~clk_sys;
  host_model host_model_i (.clk_sys, .rd_data_q, .rd_valid_q, .rd_en, .rd_addr, .aux_pin_config, .alarm_config);
  spectral_alarm_reporting spectral_alarm_reporting_i (.clk_sys, .resetn, .aux_pin_config, .alarm_config,
    .x_level_one_threshold(l1), .y_level_one_threshold(l1), .z_level_one_threshold(l1),
    .x_level_two_threshold(l2), .y_level_two_threshold(l2), .z_level_two_threshold(lz2),
    .diagnostic_status, .rec_start, .rec_done, .bin_valid, .bin_band, .bin_index, .x_bin_mag(xm),
    .y_bin_mag(ym), .z_bin_mag(zm), .rd_en, .rd_addr, .rd_data_q, .rd_valid_q, .hdr_valid_q(),
    .hdr_generic_flags_q(), .aux_pin_one_out_q(p1o), .aux_pin_one_oe_q(p1e), .aux_pin_two_out_q(p2o),
    .aux_pin_two_oe_q(p2e));
  task automatic stop_test();
    $display("checked %0d, errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        ok;
    host_model_i.rd(a, d, ok);
    if (ok !== 1'b1)
    begin
      bad_count++;
      stop_test();
    end
    else
      `CHK(d, e)
  endtask
  task automatic check_reset_values();
    for (int i = 0; i < 10; i++)
      rchk(regs[i], 16'h0000);
  endtask
  task automatic bin(input logic [2:0] b, input logic [7:0] i, input logic [15:0] x, y, z);
    @(negedge clk_sys);
    {bin_valid, bin_band, bin_index, xm, ym, zm} = {1'b1, b, i, x, y, z};
  endtask
  // Odd bands carry a critical x alarm, even bands two x warnings of which the larger wins.
  // Z alarms only on odd bands, through its own lower critical level.
  task automatic run_band(input logic [2:0] n);
    logic [7:0]  bi;
    logic [15:0] fx;
    bi = {1'b0, n, 4'h2};
    fx = (n[0] ? 16'h0003 : 16'h0001) << (2 * n + 2);
    diagnostic_status = {2'h0, 3'h5, n, 8'h00};
    @(negedge clk_sys) rec_start = 1'b1;
    @(negedge clk_sys) rec_start = 1'b0;
    bin(3'h0, 8'hff, 16'h0384, 16'h0384, 16'h0384);
    bin(n, bi, n[0] ? 16'h012c : 16'h0096, 16'h0096, n[0] ? 16'h0032 : 16'h001e);
    bin(n, bi + 8'h01, 16'h00b4, 16'h0064, 16'h0028);
    @(negedge clk_sys) bin_valid = 1'b0;
    @(negedge clk_sys) rec_done = 1'b1;
    @(negedge clk_sys) rec_done = 1'b0;
    repeat (2) @(negedge clk_sys);
    rchk(7'h40, fx | {13'h0000, n});
    rchk(7'h42, (16'h0001 << (2 * n + 2)) | {13'h0000, n});
    rchk(7'h44, n[0] ? ((16'h0003 << (2 * n + 2)) | {13'h0000, n}) : 16'h0000);
    rchk(7'h46, n[0] ? 16'h012c : 16'h00b4);
    rchk(7'h48, 16'h0096);
    rchk(7'h4a, n[0] ? 16'h0032 : 16'h0384);
    rchk(7'h70, {8'h00, n[0] ? bi : bi + 8'h01});
    rchk(7'h72, {8'h00, bi});
    rchk(7'h74, n[0] ? {8'h00, bi} : 16'h00ff);
    rchk(7'h4c, 16'h0000);
    `CHK({p1e, p1o}, 2'h3)
    `CHK({p2e, p2o}, {1'b1, n[0]})
  endtask
  task automatic check_pins();
    host_model_i.cfg(4'h1, 1'b1);
    repeat (3) @(negedge clk_sys);
    `CHK({p1e, p1o, p2e, p2o}, 4'hc)
    host_model_i.cfg(4'h2, 1'b1);
    repeat (3) @(negedge clk_sys);
    `CHK({p1e, p1o, p2e, p2o}, 4'h2)
    host_model_i.cfg(4'h3, 1'b0);
    repeat (3) @(negedge clk_sys);
    `CHK({p1e, p1o, p2e, p2o}, 4'h0)
  endtask
  // A reset in mid-run must clear every published word again.
  task automatic mid_reset();
    @(negedge clk_sys) resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    check_reset_values();
  endtask
  initial
  begin
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    check_reset_values();
    host_model_i.cfg(4'h3, 1'b1);
    for (int n = 1; n <= 6; n++)
      run_band(n[2:0]);
    check_pins();
    mid_reset();
    stop_test();
  end
endmodule // spectral_alarm_reporting_tb
`default_nettype wire
